// *** bridge_pkg.sv ***
// Shared constants and types for the two-port learning bridge
package bridge_pkg;

  localparam int unsigned ADDR_W       = 48;
  localparam int unsigned SEG_W        = 1;
  localparam int unsigned TABLE_DEPTH  = 16;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned MIN_FRAME    = 64;
  localparam int unsigned HDR_BYTES    = 12;
  localparam int unsigned CNT_W        = 12;
  localparam int unsigned WIN_FRAMES   = 256;
  localparam int unsigned FBUF_DEPTH   = 2048;
  localparam int unsigned FBUF_AW      = 11;
  localparam logic [7:0]  ERR_HI_RST   = 8'h10;
  localparam logic [7:0]  ERR_LO_RST   = 8'h04;
  localparam logic [0:0]  SEG_REPEATER = 1'h0;
  localparam logic [0:0]  SEG_EXTERNAL = 1'h1;

  typedef enum logic [1:0] {
    FWD_STORE = 2'b00,
    FWD_FRAGFREE = 2'b01,
    FWD_ADAPTIVE = 2'b10
  } fwd_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HDR    = 3'b001,
    ST_WAIT   = 3'b010,
    ST_DECIDE = 3'b011,
    ST_SEND   = 3'b100,
    ST_DROP   = 3'b101
  } fwd_state_t;

endpackage

// *** bridge_sink.sv ***
// Egress station model that collects forwarded frames
`timescale 1ns/1ps
module bridge_sink (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Pacing control
  input  wire logic       stall,
  input  wire logic       slow,
  // Egress stream
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  input  wire logic       out_seg,
  output logic            out_ready,
  // Collected totals
  output int              rx_frames,
  output int              rx_bytes,
  output int              rx_sum,
  output logic            rx_seg
);
  logic tog;
  // Ready drops while stalled, and every other cycle when slow
  assign out_ready = !stall && (!slow || tog);
  // Count each accepted byte; a frame counts on its last byte
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tog <= 1'b0;
      rx_frames <= 0;
      rx_bytes <= 0;
      rx_sum <= 0;
      rx_seg <= 1'b0;
    end else begin
      tog <= !tog;
      if (out_valid && out_ready) begin
        rx_bytes <= rx_bytes + 1;
        rx_sum <= rx_sum + out_data;
        rx_seg <= out_seg;
        if (out_last) rx_frames <= rx_frames + 1;
      end
    end
  end
endmodule

// *** frame_mem.sv ***
// Frame store with registered read data
`timescale 1ns/1ps
module frame_mem
  import bridge_pkg::*;
(
  // Clock
  input  wire logic               sys_clk,
  // Write side
  input  wire logic               wr_en,
  input  wire logic [FBUF_AW-1:0] wr_addr,
  input  wire logic [8:0]         wr_data,
  // Read side
  input  wire logic [FBUF_AW-1:0] rd_addr,
  output logic      [8:0]         rd_data
);

  logic [8:0] mem [FBUF_DEPTH];

  // Synchronous write and registered read
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// *** learning_bridge.sv ***
// Forwarding engine of a two-port learning bridge
`timescale 1ns/1ps
// What this block does
// - Learn source address and its segment of every frame of 64 bytes or more into the address table
// - Drop a frame whose destination sits on the same segment as its source
// - Take destination from header, look up table, forward only when needed
// - Store-and-forward waits for the whole frame before lookup and transmit
// - Fragment-free decides and starts sending once 64 bytes have arrived
// - Fragment-free drops runts ending before 64 bytes
// - Adaptive starts fragment-free unless entered from store-and-forward, goes store-and-forward on high error rate
// - Buffer full asserts back pressure to the sender so no frame is lost
// - Full duplex allowed only on twisted-pair 100M and fibre media
// - One port faces the repeater bus, the other the front-panel link
module learning_bridge
  import bridge_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Configuration
  input  wire bridge_pkg::fwd_mode_t cfg_mode,
  input  wire logic [7:0]           cfg_err_hi,
  input  wire logic [7:0]           cfg_err_lo,
  input  wire logic                 cfg_full_duplex,
  input  wire logic                 cfg_media_fd_ok,
  // Ingress byte stream
  input  wire logic                 in_valid,
  input  wire logic [7:0]           in_data,
  input  wire logic                 in_last,
  input  wire logic                 in_crc_err,
  input  wire logic                 in_seg,
  output logic                      in_ready,
  output logic                      back_pressure,
  // Egress byte stream
  output logic                      out_valid,
  output logic [7:0]                out_data,
  output logic                      out_last,
  output logic                      out_seg,
  input  wire logic                 out_ready,
  // Status
  output logic                      duplex_full,
  output logic                      store_active
);

  import bridge_pkg::*;

  typedef struct packed {
    fwd_state_t                    st;
    logic [FBUF_AW-1:0]            wr_ptr;
    logic [FBUF_AW-1:0]            rd_ptr;
    logic [FBUF_AW-1:0]            end_ptr;
    logic                          end_known;
    logic [CNT_W-1:0]              byte_cnt;
    logic [ADDR_W-1:0]             dst;
    logic [ADDR_W-1:0]             src;
    logic                          seg;
    logic                          fwd;
    logic                          store_mode;
    logic [7:0]                    err_cnt;
    logic [8:0]                    win_cnt;
    logic [TABLE_DEPTH-1:0]        tv;
    logic [TABLE_DEPTH*ADDR_W-1:0] ta;
    logic [TABLE_DEPTH-1:0]        ts;
    logic [IDX_W-1:0]              repl;
    logic                          rd_pend;
    logic [1:0]                    ob_cnt;
    logic [17:0]                   ob;
    logic                          full_dup;
  } bridge_state_t;

  bridge_state_t cur_ff, nxt_ff;
  logic [8:0]    mem_rd;
  logic          mem_we;

  // Table lookup shared by source learning and destination search
  function automatic logic [IDX_W:0] find(input logic [ADDR_W-1:0] a,
                                          input logic [TABLE_DEPTH-1:0] v,
                                          input logic [TABLE_DEPTH*ADDR_W-1:0] t);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < TABLE_DEPTH; i++) begin
      if (v[i] && t[i*ADDR_W +: ADDR_W] == a) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  logic [FBUF_AW-1:0] used;
  logic               buf_full;
  logic               take;
  logic [IDX_W:0]     dhit;
  logic [IDX_W:0]     shit;

  assign used     = cur_ff.wr_ptr - cur_ff.rd_ptr;
  assign buf_full = (used >= FBUF_AW'(FBUF_DEPTH - 2));
  assign in_ready = !buf_full && cur_ff.st != ST_DECIDE && !(cur_ff.end_known && cur_ff.st != ST_IDLE);
  assign back_pressure = buf_full;
  assign take     = in_valid && in_ready;
  assign mem_we   = take;
  assign dhit     = find(cur_ff.dst, cur_ff.tv, cur_ff.ta);
  assign shit     = find(cur_ff.src, cur_ff.tv, cur_ff.ta);

  frame_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (mem_we),
    .wr_addr (cur_ff.wr_ptr),
    .wr_data ({in_last, in_data}),
    .rd_addr (cur_ff.rd_ptr),
    .rd_data (mem_rd)
  );

  // Next-state computation
  always_comb begin
    logic ob_push;
    logic ob_pop;
    logic can_read;
    nxt_ff   = cur_ff;
    ob_push  = cur_ff.rd_pend;
    ob_pop   = out_valid && out_ready;
    can_read = 1'b0;
    // Duplex only where the media permit it
    nxt_ff.full_dup = cfg_full_duplex && cfg_media_fd_ok;
    if (take) begin
      nxt_ff.wr_ptr   = cur_ff.wr_ptr + FBUF_AW'(1);
      nxt_ff.byte_cnt = in_last ? '0 : cur_ff.byte_cnt + CNT_W'(1);
      if (cur_ff.byte_cnt < CNT_W'(HDR_BYTES)) begin
        if (cur_ff.byte_cnt < CNT_W'(6)) begin
          nxt_ff.dst = {cur_ff.dst[ADDR_W-9:0], in_data};
        end else begin
          nxt_ff.src = {cur_ff.src[ADDR_W-9:0], in_data};
        end
      end
      if (cur_ff.byte_cnt == '0) begin
        nxt_ff.seg = in_seg;
      end
      if (in_last) begin
        nxt_ff.end_ptr   = cur_ff.wr_ptr;
        nxt_ff.end_known = 1'b1;
        // Windowed CRC error count
        nxt_ff.win_cnt = cur_ff.win_cnt + 9'h001;
        if (in_crc_err && cur_ff.err_cnt != 8'hFF) begin
          nxt_ff.err_cnt = cur_ff.err_cnt + 8'h01;
        end
        if (cur_ff.win_cnt == 9'(WIN_FRAMES - 1)) begin
          nxt_ff.win_cnt = '0;
          nxt_ff.err_cnt = '0;
          if (cfg_mode == FWD_ADAPTIVE) begin
            if (cur_ff.err_cnt >= cfg_err_hi) begin
              nxt_ff.store_mode = 1'b1;
            end else if (cur_ff.err_cnt <= cfg_err_lo) begin
              nxt_ff.store_mode = 1'b0;
            end
          end
        end
      end
    end
    if (cfg_mode == FWD_STORE) begin
      nxt_ff.store_mode = 1'b1;
    end else if (cfg_mode == FWD_FRAGFREE) begin
      nxt_ff.store_mode = 1'b0;
    end
    case (cur_ff.st)
      ST_IDLE: begin
        nxt_ff.end_known = 1'b0;
        if (take) begin
          nxt_ff.end_known = in_last;
          nxt_ff.end_ptr   = cur_ff.wr_ptr;
          nxt_ff.st = in_last ? ST_DROP : ST_HDR;
        end
      end
      ST_HDR: begin
        // Runt ends before 64 bytes are in hand
        if (take && in_last && cur_ff.byte_cnt < CNT_W'(MIN_FRAME - 1)) begin
          nxt_ff.st = ST_DROP;
        end else if (cur_ff.end_known
                     || (!cur_ff.store_mode && cur_ff.byte_cnt >= CNT_W'(MIN_FRAME))) begin
          nxt_ff.st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        // Learn source
        if (shit[IDX_W]) begin
          nxt_ff.ts[shit[IDX_W-1:0]] = cur_ff.seg;
        end else begin
          nxt_ff.tv[cur_ff.repl] = 1'b1;
          nxt_ff.ta[cur_ff.repl*ADDR_W +: ADDR_W] = cur_ff.src;
          nxt_ff.ts[cur_ff.repl] = cur_ff.seg;
          nxt_ff.repl = cur_ff.repl + IDX_W'(1);
        end
        // Filter local, flood unknown and group
        nxt_ff.fwd = cur_ff.dst[40] || !dhit[IDX_W] || cur_ff.ts[dhit[IDX_W-1:0]] != cur_ff.seg;
        nxt_ff.st  = nxt_ff.fwd ? ST_SEND : ST_DROP;
      end
      ST_SEND, ST_DROP: begin
        can_read = (cur_ff.rd_ptr != cur_ff.wr_ptr) && !cur_ff.rd_pend
                   && (cur_ff.st == ST_DROP || cur_ff.ob_cnt == 2'd0
                       || (cur_ff.ob_cnt == 2'd1 && ob_pop));
        if (cur_ff.end_known && cur_ff.rd_ptr == cur_ff.end_ptr + FBUF_AW'(1)
            && !cur_ff.rd_pend) begin
          nxt_ff.st = ST_IDLE;
          nxt_ff.byte_cnt = '0;
          can_read = 1'b0;
        end
      end
      default: nxt_ff.st = ST_IDLE;
    endcase
    if (can_read) begin
      nxt_ff.rd_ptr = cur_ff.rd_ptr + FBUF_AW'(1);
    end
    nxt_ff.rd_pend = can_read && cur_ff.st == ST_SEND;
    // Two-entry output buffer so a stalled receiver loses nothing
    if (ob_pop) begin
      nxt_ff.ob     = {9'h000, cur_ff.ob[17:9]};
      nxt_ff.ob_cnt = cur_ff.ob_cnt - 2'd1;
    end
    if (ob_push) begin
      if (nxt_ff.ob_cnt == 2'd0) begin
        nxt_ff.ob[8:0] = mem_rd;
      end else begin
        nxt_ff.ob[17:9] = mem_rd;
      end
      nxt_ff.ob_cnt = nxt_ff.ob_cnt + 2'd1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs
  assign out_valid    = cur_ff.ob_cnt != 2'd0;
  assign out_data     = cur_ff.ob[7:0];
  assign out_last     = cur_ff.ob[8];
  assign out_seg      = ~cur_ff.seg;
  assign duplex_full  = cur_ff.full_dup;
  assign store_active = cur_ff.store_mode;

  // Checks
  property p_bp;
    @(posedge sys_clk) disable iff (!reset_n) buf_full |-> !in_ready;
  endproperty
  a_bp: assert property (p_bp) else $error("ready while full");
  property p_dup;
    @(posedge sys_clk) disable iff (!reset_n) !cfg_media_fd_ok |=> !duplex_full;
  endproperty
  a_dup: assert property (p_dup) else $error("full duplex on bad media");
  property p_runt;
    @(posedge sys_clk) disable iff (!reset_n)
      (cur_ff.st == ST_HDR && take && in_last && cur_ff.byte_cnt < CNT_W'(MIN_FRAME - 1))
      |=> cur_ff.st == ST_DROP;
  endproperty
  a_runt: assert property (p_runt) else $error("runt not dropped");
  property p_sf;
    @(posedge sys_clk) disable iff (!reset_n)
      (cur_ff.st == ST_HDR && cur_ff.store_mode && !cur_ff.end_known) |=> cur_ff.st != ST_DECIDE;
  endproperty
  a_sf: assert property (p_sf) else $error("early decision in store mode");
  property p_ff;
    @(posedge sys_clk) disable iff (!reset_n)
      (cur_ff.st == ST_HDR && !cur_ff.store_mode && cur_ff.byte_cnt >= CNT_W'(MIN_FRAME)
       && !(take && in_last)) |=> cur_ff.st == ST_DECIDE;
  endproperty
  a_ff: assert property (p_ff) else $error("no cut-through decision");
  property p_filt;
    @(posedge sys_clk) disable iff (!reset_n)
      (cur_ff.st == ST_DECIDE && dhit[IDX_W] && !cur_ff.dst[40]
       && cur_ff.ts[dhit[IDX_W-1:0]] == cur_ff.seg) |=> cur_ff.st == ST_DROP;
  endproperty
  a_filt: assert property (p_filt) else $error("local frame not filtered");
  property p_flood;
    @(posedge sys_clk) disable iff (!reset_n)
      (cur_ff.st == ST_DECIDE && (!dhit[IDX_W] || cur_ff.dst[40])) |=> cur_ff.st == ST_SEND;
  endproperty
  a_flood: assert property (p_flood) else $error("unknown not flooded");
  property p_learn;
    @(posedge sys_clk) disable iff (!reset_n)
      cur_ff.st == ST_DECIDE |=> find(cur_ff.src, cur_ff.tv, cur_ff.ta) != '0;
  endproperty
  a_learn: assert property (p_learn) else $error("source not learned");
  property p_drop_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
      (cur_ff.st == ST_DROP && cur_ff.ob_cnt == 2'd0 && !cur_ff.rd_pend) |=> !out_valid;
  endproperty
  a_drop_quiet: assert property (p_drop_quiet) else $error("dropped frame emitted");
  c_send: cover property (@(posedge sys_clk) cur_ff.st == ST_SEND);
  c_drop: cover property (@(posedge sys_clk) cur_ff.st == ST_DROP);
  c_store: cover property (@(posedge sys_clk) $rose(store_active));
  c_bp: cover property (@(posedge sys_clk) back_pressure);

endmodule

// *** tb_learning_bridge.sv ***
// Self-checking testbench of the learning bridge
`timescale 1ns/1ps
module tb_learning_bridge;
  import bridge_pkg::*;
  localparam logic [47:0] A = 48'h0200000000A1, B = 48'h0200000000B2, C = 48'h0200000000C3;
  localparam logic [47:0] D = 48'h0200000000D4, BC = 48'hFFFFFFFFFFFF, MC = 48'h01005E000001;
  logic       sys_clk, reset_n, cfg_full_duplex, cfg_media_fd_ok, in_valid, in_last, in_crc_err, in_seg;
  logic       in_ready, back_pressure, out_valid, out_last, out_seg, out_ready, duplex_full, store_active;
  logic       stall, slow, rx_seg, early;
  logic [7:0] cfg_err_hi, cfg_err_lo, in_data, out_data;
  fwd_mode_t  cfg_mode;
  int         rx_frames, rx_bytes, rx_sum, fsum, exp_frames, exp_bytes, exp_sum, errors, total_checks;

  learning_bridge dut (.sys_clk(sys_clk), .reset_n(reset_n), .cfg_mode(cfg_mode), .cfg_err_hi(cfg_err_hi),
    .cfg_err_lo(cfg_err_lo), .cfg_full_duplex(cfg_full_duplex), .cfg_media_fd_ok(cfg_media_fd_ok),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_crc_err(in_crc_err), .in_seg(in_seg),
    .in_ready(in_ready), .back_pressure(back_pressure), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_seg(out_seg), .out_ready(out_ready), .duplex_full(duplex_full),
    .store_active(store_active));
  bridge_sink sink (.sys_clk(sys_clk), .reset_n(reset_n), .stall(stall), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_seg(out_seg), .out_ready(out_ready),
    .rx_frames(rx_frames), .rx_bytes(rx_bytes), .rx_sum(rx_sum), .rx_seg(rx_seg));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Offer one frame byte by byte; notes egress activity before the last byte
  task automatic send(input logic [47:0] dst, input logic [47:0] src, input logic seg, input int len,
                      input logic crc);
    logic [7:0] b;
    early = 1'b0;
    fsum = 0;
    for (int i = 0; i < len; i++) begin
      b = (i < 6) ? dst[47-8*i -: 8] : (i < 12) ? src[47-8*(i-6) -: 8] : i[7:0];
      in_valid = 1'b1;
      in_data = b;
      in_last = (i == len - 1);
      in_crc_err = crc;
      in_seg = seg;
      fsum += b;
      @(posedge sys_clk);
      while (in_ready !== 1'b1) @(posedge sys_clk);
      if (out_valid === 1'b1 && i < len - 1) early = 1'b1;
      #1;
    end
    in_valid = 1'b0;
    in_last = 1'b0;
    in_data = ~in_data;
  endtask

  // Wait for egress to settle, then compare the totals
  task automatic settle(input logic go, input logic seg, input int len);
    if (go) begin
      exp_frames++;
      exp_bytes += len;
      exp_sum += fsum;
    end
    for (int k = 0; k < 6000 && rx_frames != exp_frames; k++) @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    #1;
    chk("frames", rx_frames, exp_frames);
    chk("bytes", rx_bytes, exp_bytes);
    chk("sum", rx_sum, exp_sum);
    if (go) chk("seg", rx_seg, !seg);
  endtask

  task automatic fwd(input logic [47:0] dst, input logic [47:0] src, input logic seg, input int len,
                     input logic go);
    send(dst, src, seg, len, 1'b0);
    settle(go, seg, len);
  endtask

  // Learning, filtering and flooding
  task automatic t_filter();
    fwd(C, A, 1'b0, 80, 1'b1);
    fwd(A, B, 1'b0, 80, 1'b0);
    fwd(A, D, 1'b1, 80, 1'b1);
    fwd(BC, D, 1'b1, 70, 1'b1);
    fwd(MC, B, 1'b0, 64, 1'b1);
  endtask

  // Store versus cut-through timing and runt drop, slow receiver
  task automatic t_modes();
    slow = 1'b1;
    cfg_mode = FWD_STORE;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("store_active", store_active, 1'b1);
    fwd(D, A, 1'b0, 100, 1'b1);
    chk("early_store", early, 1'b0);
    cfg_mode = FWD_FRAGFREE;
    fwd(D, A, 1'b0, 300, 1'b1);
    chk("early_cut", early, 1'b1);
    fwd(D, A, 1'b0, 63, 1'b0);
    slow = 1'b0;
  endtask

  // Stalled receiver fills the buffer; nothing may be lost
  task automatic t_bp();
    logic seen;
    stall = 1'b1;
    fork
      send(48'h0200000000E5, 48'h0200000000F6, 1'b1, 2100, 1'b0);
      begin
        for (int k = 0; k < 4000 && back_pressure !== 1'b1; k++) @(posedge sys_clk);
        seen = back_pressure;
        repeat (20) @(posedge sys_clk);
        #1;
        stall = 1'b0;
      end
    join
    chk("back_pressure", seen, 1'b1);
    settle(1'b1, 1'b1, 2100);
  endtask

  // Duplex only where the media allows it
  task automatic t_duplex();
    for (int k = 0; k < 4; k++) begin
      cfg_full_duplex = k[1];
      cfg_media_fd_ok = k[0];
      repeat (2) @(posedge sys_clk);
      #1;
      chk("duplex_full", duplex_full, k == 3);
    end
  endtask

  // Errored frames push adaptive mode into store-and-forward
  task automatic t_adaptive();
    cfg_err_hi = 8'h02;
    cfg_err_lo = 8'h00;
    cfg_mode = FWD_ADAPTIVE;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("adaptive_start", store_active, 1'b0);
    repeat (2) send(D, A, 1'b0, 70, 1'b1);
    // Errored one-byte runts carry the frame window to its end
    repeat (WIN_FRAMES) send(D, A, 1'b0, 1, 1'b1);
    repeat (40) @(posedge sys_clk);
    #1;
    chk("adaptive_store", store_active, 1'b1);
  endtask

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {reset_n, in_valid, in_last, in_crc_err, in_seg, stall, slow, cfg_full_duplex, cfg_media_fd_ok} = '0;
    {in_data, cfg_err_hi, cfg_err_lo} = {8'h00, 8'h10, 8'h04};
    cfg_mode = FWD_FRAGFREE;
    {exp_frames, exp_bytes, exp_sum, errors, total_checks} = '0;
    repeat (8) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    chk("in_ready_rst", in_ready, 1'b1);
    chk("out_seg_rst", out_seg, 1'b1);
    chk("out_valid_rst", out_valid, 1'b0);
    t_filter();
    t_modes();
    t_bp();
    t_duplex();
    t_adaptive();
    end_of_test();
  end
endmodule
